// File: logic/ats_analyzer.sv
// capture core: probe comparators, windowed capture buffer, trigger status
// assumes probes and sequencer trigger are on clk; the external trigger is a pin
`timescale 1ns/1ps
module ats_analyzer
  import ats_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic [SAMPLE_WIDTH-1:0] probeData,
  input  wire logic                    seqTrigger,
  input  wire logic                    externalTriggerInput,
  input  wire logic [2:0]              trigMode,
  input  wire logic [1:0]              trigCondition,
  input  wire logic [PROBE_COUNT-1:0]  probeParticipate,
  input  wire logic [SAMPLE_WIDTH-1:0] probeCompareValue,
  input  wire logic [SAMPLE_WIDTH-1:0] probeCompareMask,
  input  wire logic                    captureQualified,
  input  wire logic [WIN_W-1:0]        windowCount,
  input  wire logic [CNT_W-1:0]        windowDepth,
  input  wire logic [ADDR_W-1:0]       triggerPosition,
  input  wire logic                    arm,
  input  wire logic [ADDR_W-1:0]       readIndex,
  output logic [SAMPLE_WIDTH-1:0]      readData_q,
  output logic                         triggered_q,
  output logic                         captureDone_q,
  output logic                         captureBusy_q,
  output logic [WIN_W-1:0]             windowsDone_q,
  output logic [ADDR_W-1:0]            triggerIndex_q
);

  // ==========================================================
  // declarations
  ats_state_type          state_q;
  logic [2:0]             mode_q;
  logic [1:0]             cond_q;
  logic                   qualified_q;
  logic [WIN_W-1:0]       numWin_q;
  logic [CNT_W-1:0]       depth_q;
  logic [CNT_W-1:0]       trigPos_q;
  logic [WIN_W-1:0]       winIdx_q;
  logic [ADDR_W-1:0]      winBase_q;
  logic [CNT_W-1:0]       wrPtr_q;
  logic [CNT_W-1:0]       preCount_q;
  logic [CNT_W-1:0]       postLeft_q;
  logic                   extSync1_q;
  logic                   extSync2_q;
  logic                   extPrev_q;
  logic [PROBE_COUNT-1:0] hit;
  logic                   sampleEn;
  logic                   preReady;
  logic                   accept;
  logic                   memWrite;
  logic                   windowEnd;
  logic [ADDR_W-1:0]      wrAddr;
  logic [SAMPLE_WIDTH-1:0] mem [MEM_DEPTH];

  ats_trig_if trigBus ();

  ats_trigger_select u_select (
    .bus (trigBus.sel)
  );

  // ==========================================================
  // external trigger synchroniser and edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // reset high: a pin that idles high must not look like a rise after reset
      extSync1_q <= 1'b1;
      extSync2_q <= 1'b1;
      extPrev_q  <= 1'b1;
    end
    else
    begin
      extSync1_q <= externalTriggerInput; // see [R12]
      extSync2_q <= extSync1_q;
      extPrev_q  <= extSync2_q;
    end
  end

  // ==========================================================
  // probe comparators
  genvar p;
  generate
    for (p = 0; p < PROBE_COUNT; p++)
    begin : g_cmp
      assign hit[p] = ((probeData[p*PROBE_WIDTH +: PROBE_WIDTH]
                        ^ probeCompareValue[p*PROBE_WIDTH +: PROBE_WIDTH])
                       & probeCompareMask[p*PROBE_WIDTH +: PROBE_WIDTH]) == '0;
    end
  endgenerate

  assign trigBus.mode        = mode_q;
  assign trigBus.cond        = cond_q;
  assign trigBus.compHit     = hit;
  assign trigBus.participate = probeParticipate;
  assign trigBus.seqTrig     = seqTrigger;
  assign trigBus.extEdge     = extSync2_q & ~extPrev_q; // see [R03] [R12]

  // ==========================================================
  // capture control
  // the trigger sample is always stored, even when qualification would drop it
  assign sampleEn  = ~qualified_q | trigBus.compCond; // see [R07]
  assign preReady  = preCount_q >= trigPos_q; // see [R08]
  assign accept    = (state_q == ST_ARMED) && preReady && trigBus.trigger;
  assign memWrite  = ((state_q == ST_ARMED) && (sampleEn || accept))
                     || ((state_q == ST_POST) && sampleEn);
  assign windowEnd = (accept && (postLeft_q == '0) && (trigPos_q == depth_q - 7'h01))
                     || ((state_q == ST_POST) && sampleEn && (postLeft_q == 7'h01));
  assign wrAddr    = ADDR_W'(winBase_q + wrPtr_q[ADDR_W-1:0]);

  // configuration latched only while idle or done
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_q      <= RST_MODE;
      cond_q      <= COND_AND;
      qualified_q <= 1'b0;
      numWin_q    <= RST_WINS;
      depth_q     <= RST_DEPTH;
      trigPos_q   <= '0;
    end
    else if (arm && ((state_q == ST_IDLE) || (state_q == ST_DONE)))
    begin
      mode_q      <= trigMode;
      cond_q      <= trigCondition;
      qualified_q <= captureQualified; // see [R07]
      numWin_q    <= windowCount; // see [R09]
      depth_q     <= windowDepth; // see [R09]
      trigPos_q   <= {1'b0, triggerPosition}; // see [R08]
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q    <= ST_IDLE;
      winIdx_q   <= '0;
      winBase_q  <= '0;
      wrPtr_q    <= '0;
      preCount_q <= '0;
      postLeft_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE, ST_DONE:
          if (arm)
          begin
            state_q    <= ST_ARMED;
            winIdx_q   <= '0;
            winBase_q  <= '0;
            wrPtr_q    <= '0;
            preCount_q <= '0;
          end
        ST_ARMED, ST_POST:
        begin
          if (memWrite)
            wrPtr_q <= (wrPtr_q == depth_q - 7'h01) ? '0 : wrPtr_q + 7'h01;
          if ((state_q == ST_ARMED) && sampleEn && !preReady)
            preCount_q <= preCount_q + 7'h01;
          if (accept)
          begin
            state_q    <= ST_POST;
            postLeft_q <= depth_q - trigPos_q - 7'h01;
          end
          else if ((state_q == ST_POST) && sampleEn)
            postLeft_q <= postLeft_q - 7'h01;
          if (windowEnd)
          begin
            wrPtr_q    <= '0;
            preCount_q <= '0;
            if (winIdx_q == numWin_q - 4'h1)
              state_q <= ST_DONE;
            else
            begin
              state_q   <= ST_ARMED;
              winIdx_q  <= winIdx_q + 4'h1;
              winBase_q <= ADDR_W'(winBase_q + depth_q[ADDR_W-1:0]);
            end
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // status
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      triggered_q    <= 1'b0;
      captureDone_q  <= 1'b0;
      captureBusy_q  <= 1'b0;
      windowsDone_q  <= '0;
      triggerIndex_q <= '0;
    end
    else if (arm && ((state_q == ST_IDLE) || (state_q == ST_DONE)))
    begin
      triggered_q   <= 1'b0;
      captureDone_q <= 1'b0;
      captureBusy_q <= 1'b1;
      windowsDone_q <= '0;
    end
    else
    begin
      if (accept)
      begin
        triggered_q    <= 1'b1; // see [R10]
        triggerIndex_q <= wrAddr;
      end
      if (windowEnd)
      begin
        windowsDone_q <= windowsDone_q + 4'h1;
        if (winIdx_q == numWin_q - 4'h1)
        begin
          captureDone_q <= 1'b1; // see [R10]
          captureBusy_q <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // buffer, written by index, read one cycle late
  always_ff @(posedge clk)
  begin
    if (memWrite)
      mem[wrAddr] <= probeData;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      readData_q <= '0;
    else
      readData_q <= mem[readIndex];
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  ext_edge_seen_a: assert property ($rose(extSync2_q) |-> trigBus.extEdge) // see [R12]
    else $error("external rise not turned into an edge");
  ext_only_a: assert property ((mode_q == MODE_EXT) |-> (trigBus.trigger == trigBus.extEdge)) // see [R03]
    else $error("external-only trigger differs from edge");
  comp_and_a: assert property (((mode_q == MODE_COMP) && (cond_q == COND_AND)
      && (&(hit | ~probeParticipate))) |-> trigBus.trigger) // see [R01]
    else $error("comparator AND did not trigger");
  comp_nor_a: assert property (((mode_q == MODE_COMP) && (cond_q == COND_NOR))
      |-> (trigBus.trigger == ~|(hit & probeParticipate))) // see [R06]
    else $error("comparator NOR wrong");
  comp_gated_a: assert property (((mode_q == MODE_EXT) || (mode_q == MODE_SEQ))
      && !trigBus.extEdge && !seqTrigger |-> !trigBus.trigger) // see [R05]
    else $error("comparator acted outside its modes");
  seq_only_a: assert property ((mode_q == MODE_SEQ) |-> (trigBus.trigger == seqTrigger)) // see [R02]
    else $error("sequencer-only trigger wrong");
  or_combined_a: assert property (((mode_q == MODE_COMP_EXT) || (mode_q == MODE_SEQ_EXT))
      && trigBus.extEdge |-> trigBus.trigger) // see [R04]
    else $error("combined mode lost external edge");
  trig_status_a: assert property (accept |=> triggered_q && (triggerIndex_q == $past(wrAddr))) // see [R10]
    else $error("trigger status not reported");
  trig_pos_a: assert property (accept |-> (preCount_q == trigPos_q)) // see [R08]
    else $error("trigger taken before pre-trigger fill");
  qual_drop_a: assert property ((state_q == ST_POST) && qualified_q && !trigBus.compCond
      |-> !memWrite) // see [R07]
    else $error("unqualified sample stored");
  cfg_hold_a: assert property ((state_q == ST_ARMED) || (state_q == ST_POST)
      |=> $stable(depth_q) && $stable(numWin_q)) // see [R09]
    else $error("window setup changed while armed");
  done_last_a: assert property ($rose(captureDone_q) |-> (windowsDone_q == $past(numWin_q))) // see [R10]
    else $error("capture done before last window");

  ext_trig_c:  cover property ((mode_q == MODE_EXT) && accept);
  seq_ext_c:   cover property ((mode_q == MODE_SEQ_EXT) && accept && trigBus.extEdge);
  qual_done_c: cover property (qualified_q && $rose(captureDone_q));
  multi_win_c: cover property ((numWin_q > 4'h1) && $rose(captureDone_q));

endmodule // ats_analyzer

// File: logic/ats_pkg.sv
// constants, encodings and state type of the analyzer trigger-mode select block
// assumes one 25 MHz clock; the host drives configuration as plain ports
//
// Functional notes
// [R01] comparator-only mode triggers when the global comparator function holds
// [R02] sequencer-only mode triggers only on the sequencer program's trigger
// [R03] external-only mode triggers on a low-to-high change of the external input
// [R04] the combined modes OR the external edge with the comparator or sequencer trigger
// [R05] comparator triggering acts only in comparator-only or comparator-or-external mode
// [R06] the comparator condition is one global AND, OR, NAND or NOR over participants
// [R07] always-capture or comparator-qualified capture decides which samples are stored
// [R08] the trigger may sit at any sample index of the capture window
// [R09] window count and window depth are set by the host before capture is armed
// [R10] trigger status and capture-complete status are visible to the host
// [R11] the host never triggers on probes built partly from constant bits
// [R12] the external input is sampled on the capture clock and edged against its last sample
package ats_pkg;

  // ==========================================================
  // geometry
  localparam int PROBE_COUNT  = 4;
  localparam int PROBE_WIDTH  = 8;
  localparam int SAMPLE_WIDTH = PROBE_COUNT * PROBE_WIDTH;
  localparam int MEM_DEPTH    = 64;
  localparam int ADDR_W       = 6;
  localparam int CNT_W        = ADDR_W + 1;
  localparam int WIN_W        = 4;

  // ==========================================================
  // trigger modes
  localparam logic [2:0] MODE_COMP     = 3'h0;
  localparam logic [2:0] MODE_SEQ      = 3'h1;
  localparam logic [2:0] MODE_EXT      = 3'h2;
  localparam logic [2:0] MODE_COMP_EXT = 3'h3;
  localparam logic [2:0] MODE_SEQ_EXT  = 3'h4;

  // ==========================================================
  // global comparator functions
  localparam logic [1:0] COND_AND  = 2'h0;
  localparam logic [1:0] COND_OR   = 2'h1;
  localparam logic [1:0] COND_NAND = 2'h2;
  localparam logic [1:0] COND_NOR  = 2'h3;

  // ==========================================================
  // reset values
  localparam logic [2:0]       RST_MODE  = MODE_COMP;
  localparam logic [WIN_W-1:0] RST_WINS  = 4'h1;
  localparam logic [CNT_W-1:0] RST_DEPTH = 7'h40;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ARMED = 4'h2,
    ST_POST  = 4'h4,
    ST_DONE  = 4'h8
  } ats_state_type;

endpackage

// File: logic/ats_trig_if.sv
// signals between the capture core and the trigger selector
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface ats_trig_if;
  import ats_pkg::*;

  logic [2:0]             mode;
  logic [1:0]             cond;
  logic [PROBE_COUNT-1:0] compHit;
  logic [PROBE_COUNT-1:0] participate;
  logic                   seqTrig;
  logic                   extEdge;
  logic                   compCond;
  logic                   trigger;

  modport sel  (input mode, cond, compHit, participate, seqTrig, extEdge,
                output compCond, trigger);
  modport core (output mode, cond, compHit, participate, seqTrig, extEdge,
                input compCond, trigger);
endinterface

// File: logic/ats_trigger_select.sv
// trigger selector: global comparator function and mode multiplexing
// assumes comparator hits and edge are valid in the same cycle
`timescale 1ns/1ps
module ats_trigger_select
  import ats_pkg::*;
(
  ats_trig_if.sel bus
);

  // ==========================================================
  // global comparator function
  // non-participants are neutral so they never decide the result
  logic allTrue;
  logic anyTrue;
  logic compFn;
  logic compActive;

  always_comb
  begin
    allTrue = &(bus.compHit | ~bus.participate);
    anyTrue = |(bus.compHit & bus.participate);
    case (bus.cond) // see [R06]
      COND_AND:  compFn = allTrue;
      COND_OR:   compFn = anyTrue;
      COND_NAND: compFn = ~allTrue;
      default:   compFn = ~anyTrue;
    endcase
  end

  assign bus.compCond = compFn; // see [R01]
  assign compActive = (bus.mode == MODE_COMP) || (bus.mode == MODE_COMP_EXT); // see [R05]

  // ==========================================================
  // mode select
  always_comb
  begin
    case (bus.mode)
      MODE_COMP:     bus.trigger = compFn; // see [R01]
      MODE_SEQ:      bus.trigger = bus.seqTrig; // see [R02]
      MODE_EXT:      bus.trigger = bus.extEdge; // see [R03]
      MODE_COMP_EXT: bus.trigger = (compFn & compActive) | bus.extEdge; // see [R04]
      MODE_SEQ_EXT:  bus.trigger = bus.seqTrig | bus.extEdge; // see [R04]
      default:       bus.trigger = 1'b0;
    endcase
  end

endmodule // ats_trigger_select

// File: test/ats_host_model.sv
// host-side model: arms the analyzer and waits for capture complete
// assumes the bench has settled all configuration before it raises startReq
`timescale 1ns/1ps
module ats_host_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic startReq,
  input  wire logic captureDone,
  output logic      arm,
  output logic      ready,
  output logic      timedOut
);
  int n;

  // ==========================================================
  // arm and poll
  // probes with constant bits are never handed to a trigger here
  initial
  begin
    arm      = 1'b0;
    ready    = 1'b1;
    timedOut = 1'b0;
    forever
    begin
      @(negedge clk);
      if (startReq === 1'b1 && ready && rstn === 1'b1)
      begin
        ready = 1'b0;
        arm   = 1'b1;
        @(negedge clk);
        arm = 1'b0;
        // one spare cycle so a stale done flag is never taken as fresh
        @(negedge clk);
        n = 0;
        while (captureDone !== 1'b1 && n < 300)
        begin
          @(negedge clk);
          n++;
        end
        if (n >= 300)
          timedOut = 1'b1;
        ready = 1'b1;
      end
    end
  end
endmodule // ats_host_model

// File: test/ats_analyzer_tb_top.sv
// self-checking bench for the analyzer trigger-mode select block
// assumes the host model in ats_host_model.sv; inputs change on falling edges
`timescale 1ns/1ps
module ats_analyzer_tb_top;
  import ats_pkg::*;

  typedef struct {
    logic [WIN_W-1:0]  wd;
    logic [ADDR_W-1:0] idx;
    bit                useIdx;
  } ats_exp_type;

  logic                    clk;
  logic                    rstn;
  logic                    seqTrigger;
  logic                    extPin;
  logic                    captureQualified;
  logic                    arm;
  logic                    startReq;
  logic                    hostReady;
  logic                    hostTimeout;
  logic [SAMPLE_WIDTH-1:0] probeData;
  logic [SAMPLE_WIDTH-1:0] cmpVal;
  logic [SAMPLE_WIDTH-1:0] readData;
  logic [2:0]              trigMode;
  logic [1:0]              trigCondition;
  logic [PROBE_COUNT-1:0]  participate;
  logic [WIN_W-1:0]        windowCount;
  logic [WIN_W-1:0]        windowsDone;
  logic [CNT_W-1:0]        windowDepth;
  logic [ADDR_W-1:0]       triggerPosition;
  logic [ADDR_W-1:0]       triggerIndex;
  logic [ADDR_W-1:0]       readIndex;
  logic                    triggered;
  logic                    captureDone;
  logic                    captureBusy;
  int                      errors = 0;
  int                      checked = 0;
  bit                      doneSeen = 0;
  ats_exp_type             expQ[$];

  ats_analyzer dut_u (
    .clk(clk), .rstn(rstn), .probeData(probeData), .seqTrigger(seqTrigger),
    .externalTriggerInput(extPin), .trigMode(trigMode), .trigCondition(trigCondition),
    .probeParticipate(participate), .probeCompareValue(cmpVal),
    .probeCompareMask(32'hFFFFFFFF), .captureQualified(captureQualified),
    .windowCount(windowCount), .windowDepth(windowDepth),
    .triggerPosition(triggerPosition), .arm(arm), .readIndex(readIndex),
    .readData_q(readData), .triggered_q(triggered), .captureDone_q(captureDone),
    .captureBusy_q(captureBusy), .windowsDone_q(windowsDone),
    .triggerIndex_q(triggerIndex));

  ats_host_model host_u (
    .clk(clk), .rstn(rstn), .startReq(startReq), .captureDone(captureDone),
    .arm(arm), .ready(hostReady), .timedOut(hostTimeout));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================
  // reporting
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // stimulus
  // every byte of ~cmpVal differs, so hits are all or none
  task automatic setComp(logic [1:0] cond, bit on);
    probeData = (on ^ cond[1]) ? cmpVal : ~cmpVal;
  endtask

  // src: 0 comparator, 1 sequencer, 2 external pin; an unused comparator or sequencer acts as a decoy, the pin stays high
  task automatic run(logic [2:0] mode, logic [1:0] cond, int src, int d, int pos,
                     int depth, int wins, bit qual);
    ats_exp_type e;
    int          n;
    bit          usesComp;
    bit          usesSeq;
    logic [SAMPLE_WIDTH-1:0] trigSample;
    usesComp = (mode == MODE_COMP || mode == MODE_COMP_EXT);
    usesSeq = (mode == MODE_SEQ || mode == MODE_SEQ_EXT);
    trigMode = mode;
    trigCondition = cond;
    triggerPosition = pos[ADDR_W-1:0];
    windowDepth = depth[CNT_W-1:0];
    windowCount = wins[WIN_W-1:0];
    captureQualified = qual;
    participate = 4'h1 | 4'($urandom);
    cmpVal = $urandom;
    setComp(cond, !usesComp);
    seqTrigger = !usesSeq;
    n = qual ? 0 : (wins > 1) ? (wins - 1) * depth + pos : ((d > pos) ? d : pos) % depth;
    e.idx = n[ADDR_W-1:0];
    e.wd = wins[WIN_W-1:0];
    e.useIdx = (src != 2);
    expQ.push_back(e);
    startReq = 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (arm !== 1'b1 && n < 20);
    check("host armed", arm, 1'b1);
    @(negedge clk);
    startReq = 1'b0;
    repeat (d) @(negedge clk);
    if (d > 0)
    begin
      check("busy while armed", captureBusy, 1'b1);
      check("no early trigger", triggered, 1'b0);
    end
    if (src == 0)
      setComp(cond, 1'b1);
    else if (src == 1)
      seqTrigger = 1'b1;
    else
    begin
      extPin = 1'b0;
      @(negedge clk);
      extPin = 1'b1;
    end
    // probe value held from the trigger on, so it is the trigger sample
    trigSample = probeData;
    n = 0;
    while (hostReady !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 400 || hostTimeout === 1'b1)
    begin
      errors++;
      summarize();
    end
    else if (src != 2)
    begin
      readIndex = e.idx;
      @(negedge clk);
      check("trigger sample", readData, trigSample);
    end
  endtask

  // ==========================================================
  // result monitor
  initial
  begin
    ats_exp_type e;
    forever
    begin
      @(negedge clk);
      if (captureDone === 1'b1 && !doneSeen)
      begin
        doneSeen = 1'b1;
        if (expQ.size() == 0)
          check("unexpected done", 1'b1, 1'b0);
        else
        begin
          e = expQ.pop_front();
          check("windows done", windowsDone, e.wd);
          check("triggered", triggered, 1'b1);
          check("busy at done", captureBusy, 1'b0);
          if (e.useIdx)
            check("trigger index", triggerIndex, e.idx);
        end
      end
      else if (captureDone !== 1'b1)
        doneSeen = 1'b0;
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    rstn = 1'b0;
    startReq = 1'b0;
    seqTrigger = 1'b0;
    // pin high through reset: a level must never count as an edge
    extPin = 1'b1;
    probeData = 32'h00000000;
    cmpVal = 32'h00000000;
    participate = 4'hF;
    trigMode = MODE_COMP;
    trigCondition = COND_AND;
    captureQualified = 1'b0;
    windowCount = 4'h1;
    windowDepth = 7'h04;
    triggerPosition = 6'h00;
    readIndex = 6'h00;
    void'($urandom(45087));
    repeat (6) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    for (int c = 0; c < 4; c++)
      run(MODE_COMP, c[1:0], 0, 2, 1, 4, 1, 0);
    run(MODE_SEQ, COND_AND, 1, 5, 0, 4, 1, 0);
    run(MODE_EXT, COND_OR, 2, 3, 0, 4, 1, 0);
    run(MODE_COMP_EXT, COND_NOR, 2, 2, 2, 4, 1, 0);
    run(MODE_COMP_EXT, COND_AND, 0, 3, 0, 8, 1, 0);
    run(MODE_SEQ_EXT, COND_OR, 2, 1, 1, 4, 1, 0);
    run(MODE_SEQ_EXT, COND_NAND, 1, 4, 3, 4, 1, 0);
    run(MODE_COMP, COND_OR, 0, 0, 5, 8, 3, 0);
    run(MODE_COMP, COND_OR, 0, 6, 0, 4, 1, 1);
    repeat (2) @(negedge clk);
    check("pending results", expQ.size(), 0);
    summarize();
  end
endmodule // ats_analyzer_tb_top
